//--- nv_prog_pkg.sv
// Notes on behaviour
// - any write to register 0x78 is the burn command; the store is programmed from the working registers and the data is ignored.
// - the host waits 20 ms after a burn and then reads the fault flag, which is 0 on success and 1 on failure.
// - after a good burn the host writes any value to register 0x79 as the reload command.
// - with auto-refresh on, the device periodically restores working registers 0x07..0x15 from the store.
// - the store supports six programming operations between resets; sys_rst clears the burn count.
// - the reload command copies the stored contents back into the working registers.
package nv_prog_pkg;
  localparam logic [7:0] cfg_first_addr = 8'h07;
  localparam logic [7:0] cfg_last_addr = 8'h15;
  localparam int cfg_count = 15;
  localparam logic [7:0] nv_burn_trigger_addr = 8'h78;
  localparam logic [7:0] nv_reload_trigger_addr = 8'h79;
  localparam logic [7:0] cfg_reset_value = 8'h00;
  localparam logic [2:0] burn_budget = 3'h6;
  // burn time of the store, in microseconds
  localparam int burn_time_us = 20000;
  localparam int clk_mhz = 125;
  localparam int burn_cycles = burn_time_us * clk_mhz;
  // auto-refresh period, in microseconds
  localparam int refresh_time_us = 1000;
  localparam int refresh_cycles = refresh_time_us * clk_mhz;
  typedef enum logic [1:0] {st_idle, st_burn, st_reload, st_refresh} nv_state_t;
endpackage : nv_prog_pkg

//--- nv_cell_array.sv
`timescale 1ns/1ps
// one-time-programmable store: a byte can only gain ones
module nv_cell_array (
  input wire logic core_clk,
  input wire logic [3:0] wr_idx,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_idx,
  output logic [7:0] rd_data
);
  logic [7:0] cells_r [0:nv_prog_pkg::cfg_count-1];

  // no reset: stored bits survive a reset; initial content erased
  initial
  begin
    for (int i = 0; i < nv_prog_pkg::cfg_count; i++) cells_r[i] = 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      cells_r[wr_idx] <= cells_r[wr_idx] | wr_data;
  end

  assign rd_data = cells_r[rd_idx];
endmodule : nv_cell_array

//--- nv_config_programming.sv
`timescale 1ns/1ps
// working configuration registers with burn, reload and auto-refresh
module nv_config_programming #(
  parameter int burn_cycles = nv_prog_pkg::burn_cycles,
  parameter int refresh_cycles = nv_prog_pkg::refresh_cycles
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  input wire logic auto_refresh_en,
  output logic nv_program_fault,
  output logic busy,
  output logic [2:0] burns_used
);
  logic [7:0] work_r [0:nv_prog_pkg::cfg_count-1];
  nv_prog_pkg::nv_state_t state_r;
  logic [31:0] timer_r;
  logic [31:0] refresh_timer_r;
  logic [3:0] idx_r;
  logic [2:0] burns_r;
  logic fault_r;
  logic [7:0] rd_data_r;
  logic [7:0] nv_rd;

  // address decode and sequencer status, all continuous
  wire in_cfg = reg_addr >= nv_prog_pkg::cfg_first_addr
    && reg_addr <= nv_prog_pkg::cfg_last_addr;
  wire [3:0] wr_idx = 4'(reg_addr - nv_prog_pkg::cfg_first_addr);
  wire rd_in_cfg = rd_addr >= nv_prog_pkg::cfg_first_addr
    && rd_addr <= nv_prog_pkg::cfg_last_addr;
  wire [3:0] rd_idx = 4'(rd_addr - nv_prog_pkg::cfg_first_addr);
  wire idle = state_r == nv_prog_pkg::st_idle;
  wire burn_cmd = reg_wr && reg_addr == nv_prog_pkg::nv_burn_trigger_addr;
  wire reload_cmd = reg_wr && reg_addr == nv_prog_pkg::nv_reload_trigger_addr;
  wire budget_left = burns_r < nv_prog_pkg::burn_budget;
  wire last_idx = idx_r == 4'(nv_prog_pkg::cfg_count - 1);
  wire refresh_due = auto_refresh_en && refresh_timer_r >= 32'(refresh_cycles - 1);
  wire copy_phase = state_r == nv_prog_pkg::st_reload || state_r == nv_prog_pkg::st_refresh;
  wire burn_wr = state_r == nv_prog_pkg::st_burn && timer_r == 32'h0;

  // the store is read combinationally at the walking index and written only by the burn
  nv_cell_array store (
    .core_clk(core_clk),
    .wr_idx(idx_r),
    .wr_en(burn_wr),
    .wr_data(work_r[idx_r]),
    .rd_idx(idx_r),
    .rd_data(nv_rd)
  );

  // sequencer: burn walks bytes then waits; reload and refresh copy bytes back
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= nv_prog_pkg::st_idle;
      idx_r <= 4'h0;
      timer_r <= 32'h0;
      refresh_timer_r <= 32'h0;
      burns_r <= 3'h0;
      fault_r <= 1'b0;
    end
    else
    begin
      // a refresh falling due while busy is dropped; the next period brings it back
      refresh_timer_r <= (auto_refresh_en && !refresh_due) ? refresh_timer_r + 32'h1 : 32'h0;
      unique case (state_r)
        nv_prog_pkg::st_idle:
        begin
          // a burn wins over a reload, and a reload over a refresh
          idx_r <= 4'h0;
          timer_r <= 32'h0;
          if (burn_cmd)
          begin
            if (budget_left)
            begin
              state_r <= nv_prog_pkg::st_burn;
              burns_r <= burns_r + 3'h1;
              fault_r <= 1'b0;
            end
            else
              fault_r <= 1'b1; // budget spent, burn refused
          end
          else if (reload_cmd)
            state_r <= nv_prog_pkg::st_reload;
          else if (refresh_due)
            state_r <= nv_prog_pkg::st_refresh;
        end
        nv_prog_pkg::st_burn:
        begin
          // bytes written first, then the whole burn time runs, counted from the last byte
          if (!last_idx && timer_r == 32'h0)
            idx_r <= idx_r + 4'h1;
          else if (timer_r >= 32'(burn_cycles - 1))
            state_r <= nv_prog_pkg::st_idle;
          else
            timer_r <= timer_r + 32'h1;
        end
        nv_prog_pkg::st_reload, nv_prog_pkg::st_refresh:
        begin
          // the index runs one past the last byte; idle parks it at zero again
          idx_r <= idx_r + 4'h1;
          if (last_idx)
            state_r <= nv_prog_pkg::st_idle;
        end
      endcase
    end
  end

  // working registers: host writes ignored while a copy is running
  genvar g;
  generate
    for (g = 0; g < nv_prog_pkg::cfg_count; g++)
    begin : g_work
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          work_r[g] <= nv_prog_pkg::cfg_reset_value;
        else if (copy_phase && idx_r == 4'(g))
          work_r[g] <= nv_rd;
        else if (idle && reg_wr && in_cfg && wr_idx == 4'(g))
          work_r[g] <= reg_wdata;
      end
      // a host write during a burn must not disturb what is being stored
      hold_in_burn_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == nv_prog_pkg::st_burn |=> work_r[g] == $past(work_r[g]))
        else $error("working register changed during burn");
      copy_lands_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        copy_phase && idx_r == 4'(g) |=> work_r[g] == $past(nv_rd))
        else $error("stored byte not copied back");
    end
  endgenerate

  // registered readback of the working registers
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      rd_data_r <= 8'h00;
    else
      rd_data_r <= rd_in_cfg ? work_r[rd_idx] : 8'h00;
  end

  // outputs straight from registers or the state
  assign rd_data = rd_data_r;
  assign nv_program_fault = fault_r;
  assign busy = !idle;
  assign burns_used = burns_r;

  // cycles spent in the burn state, only read by the length check below
  logic [31:0] burn_len_r;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      burn_len_r <= 32'h0;
    else if (state_r == nv_prog_pkg::st_burn)
      burn_len_r <= burn_len_r + 32'h1;
    else
      burn_len_r <= 32'h0;
  end

  // the budget is never exceeded between resets; sys_rst clears the burn count
  budget_cap_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burns_r <= nv_prog_pkg::burn_budget) else $error("burn count over budget");

  // burn acceptance, refusal and the fault flag that reports them
  sequence burn_take_s;
    idle && burn_cmd && budget_left;
  endsequence
  sequence burn_refuse_s;
    idle && burn_cmd && !budget_left;
  endsequence
  refused_burn_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burn_refuse_s |=> nv_program_fault && idle)
    else $error("burn accepted past budget");
  burn_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burn_take_s |=> state_r == nv_prog_pkg::st_burn
      && burns_r == $past(burns_r) + 3'h1) else $error("burn not started");
  fault_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burn_take_s |=> !nv_program_fault) else $error("fault kept after accepted burn");
  fault_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(idle && burn_cmd) |=> nv_program_fault == $past(nv_program_fault))
    else $error("fault changed without a burn command");
  count_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(idle && burn_cmd && budget_left) |=> burns_used == $past(burns_used))
    else $error("burn count changed without a burn");

  // one store write per byte in address order, then the burn time runs out
  sequence burn_byte_s;
    burn_wr && !last_idx;
  endsequence
  sequence burn_next_s;
    burn_wr && idx_r == $past(idx_r) + 4'h1;
  endsequence
  burn_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burn_byte_s |=> burn_next_s) else $error("burn skipped a byte");
  burn_once_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burn_wr && last_idx |=> !burn_wr) else $error("store written after last byte");
  sequence burn_end_s;
    state_r == nv_prog_pkg::st_burn ##1 idle;
  endsequence
  burn_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    burn_end_s |-> burn_len_r == 32'(burn_cycles + nv_prog_pkg::cfg_count - 1))
    else $error("burn length wrong");

  // reload and refresh each walk all fifteen bytes, then fall back to idle
  sequence copy_walk_s;
    copy_phase ##15 idle;
  endsequence
  reload_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    idle && !burn_cmd && reload_cmd |=> state_r == nv_prog_pkg::st_reload)
    else $error("reload not started");
  reload_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    idle ##1 state_r == nv_prog_pkg::st_reload |-> copy_walk_s)
    else $error("reload walk wrong length");
  refresh_go_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    idle && !burn_cmd && !reload_cmd && refresh_due |=> state_r == nv_prog_pkg::st_refresh)
    else $error("refresh missed");
  refresh_len_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    idle ##1 state_r == nv_prog_pkg::st_refresh |-> copy_walk_s)
    else $error("refresh walk wrong length");
endmodule : nv_config_programming

//--- nv_host_model.sv
`timescale 1ns/1ps
// host side: each write holds its strobe for exactly one sampled edge
module nv_host_model (
  input wire logic core_clk,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial reg_wr = 1'b0;
  initial reg_addr = 8'h00;
  initial reg_wdata = 8'h00;
  // loads, burns and reloads share this path; data of a trigger is don't-care
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
endmodule : nv_host_model

//--- nv_config_programming_tb.sv
`timescale 1ns/1ps
module nv_config_programming_tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic auto_refresh_en = 1'b0;
  logic smp = 1'b0;
  logic [7:0] rd_addr = 8'h00;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] rd_data;
  logic nv_program_fault;
  logic busy;
  logic [2:0] burns_used;
  logic [7:0] wk [15];
  logic [7:0] nv [15];
  logic [12:0] q [$];
  logic fe = 1'b0;
  logic [2:0] ue = 3'h0;
  logic par = 1'b0;
  int num_errors = 0;
  int checks_done = 0;
  always #4 core_clk = ~core_clk;
  nv_host_model host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  nv_config_programming #(.burn_cycles(20), .refresh_cycles(50)) DUT (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .rd_addr(rd_addr), .rd_data(rd_data), .auto_refresh_en(auto_refresh_en),
    .nv_program_fault(nv_program_fault), .busy(busy), .burns_used(burns_used));
  task automatic cmp(input logic [12:0] e, input logic [12:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp
  // note {busy, fault, count, byte}; the monitor checks it one edge later
  task automatic s(input logic [7:0] a, input logic b);
    logic [7:0] v;
    v = (a >= 8'h07 && a <= 8'h15) ? wk[a - 8'h07] : 8'h00;
    rd_addr <= a;
    smp <= 1'b1;
    q.push_back({b, fe, ue, v});
    @(posedge core_clk);
  endtask : s
  task automatic idle(input int n);
    smp <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask : idle
  // bounded so a stuck busy cannot hang the run
  task automatic wait_idle();
    int k;
    smp <= 1'b0;
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(posedge core_clk);
    if (busy !== 1'b0) num_errors++;
  endtask : wait_idle
  // the store only gains ones, so the expected copy is or-ed in
  task automatic burn();
    host.wr(8'h78, 8'($urandom));
    if (ue == 3'h6) fe = 1'b1;
    else
    begin
      fe = 1'b0;
      ue++;
      for (int i = 0; i < 15; i++) nv[i] = nv[i] | wk[i];
    end
    s(8'h07, !fe);
  endtask : burn
  task automatic report_and_stop();
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop
  always @(posedge core_clk)
    if (smp)
    begin
      #1;
      cmp(q.pop_front(), {busy, nv_program_fault, burns_used, rd_data});
    end
  initial
  begin
    #40000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(71201));
    for (int i = 0; i < 15; i++) wk[i] = 8'h00;
    nv = wk;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    s(8'h07, 1'b0);
    idle(0);
    for (int i = 0; i < 15; i++)
    begin
      wk[i] = 8'($urandom);
      if (i == 14) wk[i][0] = wk[i][0] ^ par ^ (^wk[i]); // even parity over all bytes
      par = par ^ (^wk[i]);
      host.wr(8'h07 + 8'(i), wk[i]);
    end
    for (int i = 6; i < 23; i++) s(8'(i), 1'b0);
    idle(0);
    burn();
    idle(31);
    s(8'h08, 1'b1);
    s(8'h08, 1'b0);
    idle(0);
    wk[0] = ~wk[0];
    host.wr(8'h07, wk[0]);
    host.wr(8'h79, 8'($urandom));
    wk = nv;
    s(8'h15, 1'b1);
    idle(12);
    s(8'h07, 1'b1);
    s(8'h07, 1'b0);
    idle(0);
    host.wr(8'h09, ~nv[2]);
    auto_refresh_en <= 1'b1;
    for (int k = 0; k < 100 && busy !== 1'b1; k++) @(posedge core_clk);
    wait_idle();
    s(8'h09, 1'b0);
    auto_refresh_en <= 1'b0;
    idle(2);
    wait_idle();
    // five more burns use up the budget; a write during each is refused
    for (int n = 0; n < 5; n++)
    begin
      wk[n] = 8'($urandom);
      // the first rewrite and its burn follow the observed reversion after two idle edges; later ones follow the 0x0a check straight away
      host.wr(8'h07 + 8'(n), wk[n]);
      burn();
      idle(0);
      host.wr(8'h0a, ~wk[3]);
      wait_idle();
      s(8'h0a, 1'b0);
      idle(0);
    end
    burn();
    idle(0);
    host.wr(8'h79, 8'($urandom));
    wk = nv;
    s(8'h15, 1'b1);
    wait_idle();
    s(8'h07, 1'b0);
    idle(2);
    report_and_stop();
  end
endmodule : nv_config_programming_tb
